// *** pkg/txdma_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the transmit DMA control
`ifndef TXDMA_REGS_VH
`define TXDMA_REGS_VH
`define TXDMA_OFF_CONTROL        12'h300
`define TXDMA_OFF_PROVISION      12'h304
`define TXDMA_OFF_TABLE_LOW      12'h308
`define TXDMA_OFF_TABLE_HIGH     12'h30c
`define TXDMA_CTL_ENABLE         0
`define TXDMA_CTL_CACHE          1
`define TXDMA_CTL_RDY_LO         2
`define TXDMA_CTL_RDY_HI         4
`define TXDMA_CTL_FR_LO          5
`define TXDMA_CTL_FR_HI          6
`define TXDMA_CTL_FLUSH          7
`define TXDMA_CTL_RESET          8'h02
`define TXDMA_PRV_BUSY           15
`define TXDMA_PRV_RNW            14
`define TXDMA_PRV_FLAG           13
`define TXDMA_PRV_RSV_HI         9
`define TXDMA_PRV_RSV_LO         8
`define TXDMA_CACHE_DEPTH        4'h6
`define TXDMA_CHANNELS           256
`define TXDMA_INDIRECT_CYCLES    2'h2
`define TXDMA_REF_W              16
`define TXDMA_FIFO_DEPTH         8
`endif

// *** rtl/txdma_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module txdma_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk,  // System clock
  input  wire             reset,     // Async reset, active high
  input  wire [WIDTH-1:0] inData,    // Write data
  input  wire             inValid,   // Write offered
  output wire             inReady,   // Room available
  output reg  [WIDTH-1:0] outData,   // Head word, registered
  output wire             outValid,  // Head word present
  input  wire             outReady   // Consumer takes head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;
  wire [AW-1:0]   rdNext;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign rdNext   = pop ? rdPtr_q + 1'b1 : rdPtr_q;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Head register reloads from memory; a write into an empty FIFO bypasses
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      outData <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      rdPtr_q <= rdNext;
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (push && (wrPtr_q == rdNext) && (count_q == {{AW{1'b0}}, pop})) begin
        outData <= inData;
      end else begin
        outData <= mem[rdNext];
      end
    end
  end
endmodule

// *** rtl/txdma_control.v ***
// Transmit DMA control: registers, channel provisioning, ready and free queue handling
`timescale 1ns/10ps
`include "txdma_regs.vh"
module txdma_control (
  input  wire        core_clk,       // 20 MHz system clock
  input  wire        reset,          // Async reset, active high
  input  wire [11:0] regAddr,        // Register byte address
  input  wire        regWrite,       // Write strobe, one cycle
  input  wire        regRead,        // Read strobe, one cycle
  input  wire [3:0]  regByteEn,      // Byte enables, active high
  input  wire [31:0] regWrData,      // Write data
  output reg  [31:0] regRdData,      // Read data, valid cycle after strobe
  output wire        txEnable,       // Enable level, from register
  input  wire [15:0] readyRef,       // Reference from ready queue
  input  wire        readyRefValid,  // Ready-queue reference available
  output wire        readyRefTake,   // Reference accepted this cycle
  input  wire [7:0]  chainLink,      // Channel of accepted chain
  output reg         chainValid,     // Chain decision valid, one cycle
  output reg         chainAccept,    // Chain appended to channel list
  output reg         chainReject,    // Chain returned to free queue
  output reg  [15:0] chainRef,       // Reference of decided chain
  input  wire [14:0] descOffset,     // Descriptor offset to translate
  output reg  [31:0] descAddr,       // Physical descriptor address
  input  wire        listsPending,   // Built lists still hold packets
  output wire        txActive,       // Transmission allowed
  input  wire [15:0] freedRef,       // Freed reference
  input  wire        freedValid,     // Freed reference offered
  output wire        freedReady,     // Freed reference taken
  output reg  [15:0] freeWrRef,      // Reference written to free queue
  output reg         freeWrValid,    // Free-queue write, held until freeWrReady takes the word
  output reg         freeWrLast,     // Last word of a block
  input  wire        freeWrReady,    // Host memory takes the word
  output reg         readyQueueIrq,  // Ready-queue threshold pulse
  output reg         freeQueueIrq    // Free-queue threshold pulse
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_DONE = 2'h2;

  reg        enable_q;
  reg        cacheEn_q;
  reg [2:0]  rdyThr_q;
  reg [1:0]  frThr_q;
  reg        flush_q;
  reg        rnw_q;
  reg        provFlag_q;
  reg [1:0]  rsv_q;
  reg [7:0]  linkIndex_q;
  reg [1:0]  indState_q;
  reg [1:0]  indCnt_q;
  reg [15:0] baseHold_q;
  reg [31:0] tableBase_q;
  reg [`TXDMA_CHANNELS-1:0] provMap_q;
  reg [5:0]  rdyCnt_q;
  reg [3:0]  blkCnt_q;
  reg [3:0]  cached_q;
  reg [3:0]  occ_q;
  reg [5:0]  rdyTarget;
  reg [3:0]  frTarget;

  wire       anyByte = |regByteEn;
  wire       wrCtl   = regWrite & anyByte & (regAddr == `TXDMA_OFF_CONTROL);
  wire       wrPrv   = regWrite & anyByte & (regAddr == `TXDMA_OFF_PROVISION);
  wire       wrLow   = regWrite & anyByte & (regAddr == `TXDMA_OFF_TABLE_LOW);
  wire       wrHigh  = regWrite & anyByte & (regAddr == `TXDMA_OFF_TABLE_HIGH);
  wire       busy    = (indState_q != ST_IDLE);

  wire [15:0] fifoRef;
  wire        fifoValid;
  wire        fifoPop;
  wire        blockEnd;

  assign txEnable     = enable_q;
  // Intake pauses near full so a rejected reference always finds room in the cache
  assign readyRefTake = enable_q & readyRefValid & (occ_q < 4'h6);
  assign txActive     = enable_q | listsPending;

  always @* begin
    case (rdyThr_q)
      3'h0:    rdyTarget = 6'h01;
      3'h1:    rdyTarget = 6'h04;
      3'h2:    rdyTarget = 6'h06;
      3'h3:    rdyTarget = 6'h08;
      3'h4:    rdyTarget = 6'h10;
      3'h5:    rdyTarget = 6'h20;
      default: rdyTarget = 6'h00;
    endcase
    case (frThr_q)
      2'h0:    frTarget = 4'h1;
      2'h1:    frTarget = 4'h4;
      2'h2:    frTarget = 4'h8;
      default: frTarget = 4'h0;
    endcase
  end

  // Register file and indirect access
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enable_q    <= 1'b0;
      cacheEn_q   <= 1'b1;
      rdyThr_q    <= 3'h0;
      frThr_q     <= 2'h0;
      flush_q     <= 1'b0;
      rnw_q       <= 1'b0;
      provFlag_q  <= 1'b0;
      rsv_q       <= 2'h0;
      linkIndex_q <= 8'h00;
      indState_q  <= ST_IDLE;
      indCnt_q    <= 2'h0;
      baseHold_q  <= 16'h0000;
      tableBase_q <= 32'h00000000;
      provMap_q   <= {`TXDMA_CHANNELS{1'b0}};
    end else begin
      if (wrCtl) begin
        enable_q  <= regWrData[`TXDMA_CTL_ENABLE];
        cacheEn_q <= regWrData[`TXDMA_CTL_CACHE];
        rdyThr_q  <= regWrData[`TXDMA_CTL_RDY_HI:`TXDMA_CTL_RDY_LO];
        frThr_q   <= regWrData[`TXDMA_CTL_FR_HI:`TXDMA_CTL_FR_LO];
      end
      // Set by a write wins; completion clears only when no new request lands
      if (wrCtl && regWrData[`TXDMA_CTL_FLUSH]) begin
        flush_q <= 1'b1;
      end else if (flush_q && (cached_q == 4'h0) && !fifoValid) begin
        flush_q <= 1'b0;
      end
      // A trigger while busy is ignored so an access in flight is not corrupted
      if (wrPrv && !busy) begin
        rnw_q       <= regWrData[`TXDMA_PRV_RNW];
        provFlag_q  <= regWrData[`TXDMA_PRV_FLAG];
        rsv_q       <= regWrData[`TXDMA_PRV_RSV_HI:`TXDMA_PRV_RSV_LO];
        linkIndex_q <= regWrData[7:0];
        indState_q  <= ST_WAIT;
        indCnt_q    <= `TXDMA_INDIRECT_CYCLES;
      end else begin
        case (indState_q)
          ST_IDLE: indState_q <= ST_IDLE;
          ST_WAIT: begin
            if (indCnt_q == 2'h1) begin
              indState_q <= ST_DONE;
            end
            indCnt_q <= indCnt_q - 2'h1;
          end
          ST_DONE: begin
            if (rnw_q) begin
              provFlag_q <= provMap_q[linkIndex_q];
            end else begin
              provMap_q[linkIndex_q] <= provFlag_q;
            end
            indState_q <= ST_IDLE;
          end
          default: indState_q <= ST_IDLE;
        endcase
      end
      if (wrLow) begin
        baseHold_q <= regWrData[15:0];
      end
      if (wrHigh) begin
        tableBase_q <= {regWrData[15:0], baseHold_q};
      end
    end
  end

  // Read data, registered
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdData <= 32'h00000000;
    end else if (regRead && anyByte) begin
      case (regAddr)
        `TXDMA_OFF_CONTROL:
          regRdData <= {24'h000000, flush_q, frThr_q, rdyThr_q, cacheEn_q, enable_q};
        `TXDMA_OFF_PROVISION:
          regRdData <= {16'h0000, busy, rnw_q, provFlag_q, 3'h0, rsv_q, linkIndex_q};
        `TXDMA_OFF_TABLE_LOW:  regRdData <= {16'h0000, tableBase_q[15:0]};
        `TXDMA_OFF_TABLE_HIGH: regRdData <= {16'h0000, tableBase_q[31:16]};
        default:               regRdData <= 32'h00000000;
      endcase
    end
  end

  // Ready-queue intake, chain decision, threshold interrupt and address translation
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdyCnt_q      <= 6'h00;
      readyQueueIrq <= 1'b0;
      chainValid    <= 1'b0;
      chainAccept   <= 1'b0;
      chainReject   <= 1'b0;
      chainRef      <= 16'h0000;
      descAddr      <= 32'h00000000;
    end else begin
      readyQueueIrq <= 1'b0;
      chainValid    <= readyRefTake;
      chainAccept   <= readyRefTake & provMap_q[chainLink];
      chainReject   <= readyRefTake & ~provMap_q[chainLink];
      if (readyRefTake) begin
        chainRef <= readyRef;
      end
      descAddr <= {tableBase_q[31:4], 4'h0} + {17'h00000, descOffset};
      if (readyRefTake && (rdyTarget != 6'h00)) begin
        if (rdyCnt_q + 6'h01 >= rdyTarget) begin
          rdyCnt_q      <= 6'h00;
          readyQueueIrq <= 1'b1;
        end else begin
          rdyCnt_q <= rdyCnt_q + 6'h01;
        end
      end
    end
  end

  // Freed references and rejected chains share the free-queue cache FIFO
  wire [15:0] cacheIn    = chainReject ? chainRef : freedRef;
  wire        cacheInVal = chainReject | freedValid;
  wire        cacheInRdy;
  assign freedReady = cacheInRdy & ~chainReject;

  txdma_fifo #(
    .WIDTH (`TXDMA_REF_W),
    .DEPTH (`TXDMA_FIFO_DEPTH),
    .AW    (3)
  ) uCache (
    .core_clk (core_clk),
    .reset    (reset),
    .inData   (cacheIn),
    .inValid  (cacheInVal),
    .inReady  (cacheInRdy),
    .outData  (fifoRef),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // Drain when a block of six is held, when caching is off, or on flush
  reg  draining_q;
  assign fifoPop  = fifoValid & (~freeWrValid | freeWrReady) & draining_q;
  assign blockEnd = ~cacheEn_q | (cached_q == 4'h1);

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cached_q     <= 4'h0;
      draining_q   <= 1'b0;
      freeWrRef    <= 16'h0000;
      freeWrValid  <= 1'b0;
      freeWrLast   <= 1'b0;
      blkCnt_q     <= 4'h0;
      freeQueueIrq <= 1'b0;
    end else begin
      freeQueueIrq <= 1'b0;
      if (!draining_q) begin
        if (!cacheEn_q && fifoValid) begin
          cached_q   <= 4'h1;
          draining_q <= 1'b1;
        end else if (cacheEn_q && fifoValid &&
                     (occ_q >= `TXDMA_CACHE_DEPTH || flush_q)) begin
          cached_q   <= (occ_q >= `TXDMA_CACHE_DEPTH) ?
                        `TXDMA_CACHE_DEPTH : occ_q;
          draining_q <= 1'b1;
        end
      end
      if (freeWrValid && freeWrReady) begin
        freeWrValid <= 1'b0;
        freeWrLast  <= 1'b0;
        if (freeWrLast && cacheEn_q && (frTarget != 4'h0)) begin
          if (blkCnt_q + 4'h1 >= frTarget) begin
            blkCnt_q     <= 4'h0;
            freeQueueIrq <= 1'b1;
          end else begin
            blkCnt_q <= blkCnt_q + 4'h1;
          end
        end
      end
      if (fifoPop) begin
        freeWrRef   <= fifoRef;
        freeWrValid <= 1'b1;
        freeWrLast  <= blockEnd;
        cached_q    <= cached_q - 4'h1;
        if (blockEnd) begin
          draining_q <= 1'b0;
        end
      end
    end
  end

  // Occupancy seen from outside the FIFO, tracked by pushes and pops
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      occ_q <= 4'h0;
    end else begin
      occ_q <= occ_q + {3'h0, cacheInVal & cacheInRdy} - {3'h0, fifoPop};
    end
  end
endmodule

// *** sim/txdma_control_asserts.sv ***
// Port-level checks for the transmit DMA control block
`timescale 1ns/10ps
module txdma_control_asserts (
  input wire        core_clk,      // Clock
  input wire        reset,         // Reset
  input wire        txEnable,      // Enable
  input wire        readyRefValid, // Ref offered
  input wire        readyRefTake,  // Ref taken
  input wire        chainValid,    // Decision
  input wire        chainAccept,   // Accepted
  input wire        chainReject,   // Rejected
  input wire [14:0] descOffset,    // Offset
  input wire [31:0] descAddr,      // Address
  input wire        listsPending,  // Lists left
  input wire        txActive,      // Transmit on
  input wire [15:0] freeWrRef,     // Free word
  input wire        freeWrValid,   // Free valid
  input wire        freeWrLast,    // Block end
  input wire        freeWrReady,   // Free ready
  input wire        readyQueueIrq, // Ready irq
  input wire        freeQueueIrq   // Free irq
);
  reg [2:0] blkCnt_q;
  // Counts non-final words of the block now being written
  always @(posedge core_clk or posedge reset)
    if (reset)
      blkCnt_q <= 3'h0;
    else if (freeWrValid && freeWrReady)
      blkCnt_q <= freeWrLast ? 3'h0 : blkCnt_q + 3'h1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence sStall; freeWrValid && !freeWrReady; endsequence
  sequence sHeld; freeWrValid && $stable(freeWrRef) && $stable(freeWrLast); endsequence
  chk_take_when_enabled:
    assert property (readyRefTake |-> txEnable && readyRefValid) else $error("take while off");
  chk_active_drain:
    assert property (txActive == (txEnable || listsPending)) else $error("txActive wrong");
  chk_word_held:
    assert property (sStall |=> sHeld) else $error("free word dropped");
  chk_block_six:
    assert property (freeWrValid && !freeWrLast |-> blkCnt_q < 3'h5) else $error("block too long");
  chk_ready_irq_cause:
    assert property (readyQueueIrq |-> $past(readyRefTake)) else $error("ready irq uncaused");
  chk_free_irq_cause:
    assert property (freeQueueIrq |-> $past(freeWrValid && freeWrReady && freeWrLast))
      else $error("free irq uncaused");
  chk_chain_decision:
    assert property (chainValid |-> $past(readyRefTake) && (chainAccept != chainReject))
      else $error("chain decision wrong");
  chk_chain_quiet:
    assert property (!chainValid |-> !chainAccept && !chainReject) else $error("stray decision");
  chk_addr_low:
    assert property (1'b1 |=> descAddr[3:0] == $past(descOffset[3:0])) else $error("addr low bits");
endmodule
bind txdma_control txdma_control_asserts u_chk (.core_clk(core_clk), .reset(reset),
  .txEnable(txEnable), .readyRefValid(readyRefValid), .readyRefTake(readyRefTake),
  .chainValid(chainValid), .chainAccept(chainAccept), .chainReject(chainReject),
  .descOffset(descOffset), .descAddr(descAddr), .listsPending(listsPending),
  .txActive(txActive), .freeWrRef(freeWrRef), .freeWrValid(freeWrValid),
  .freeWrLast(freeWrLast), .freeWrReady(freeWrReady), .readyQueueIrq(readyQueueIrq),
  .freeQueueIrq(freeQueueIrq));

// *** sim/txdma_host_mem.sv ***
// Host memory model: ready-queue source and stalling free-queue sink
`timescale 1ns/10ps
module txdma_host_mem (
  input  wire        core_clk,      // Clock
  input  wire        reset,         // Reset
  input  wire [7:0]  offerNum,      // Refs to queue
  input  wire        offerLoad,     // Load offerNum
  output wire [15:0] readyRef,      // Ready ref
  output wire        readyRefValid, // Ref present
  input  wire        readyRefTake,  // Device takes
  input  wire [15:0] freeWrRef,     // Free word
  input  wire        freeWrValid,   // Word offered
  input  wire        freeWrLast,    // Block end
  output reg         freeWrReady,   // Accepts word
  output reg  [7:0]  pendQ,         // Refs untaken
  output reg  [15:0] wordCnt,       // Words stored
  output reg  [15:0] lastCnt,       // Blocks stored
  output reg  [15:0] lastRef        // Latest word
);
  reg [15:0] refQ;
  integer    seed;
  initial seed = 32'h65a0;
  assign readyRefValid = pendQ != 8'h0;
  // An empty queue shows the inverse so a stale reference never looks fresh
  assign readyRef = readyRefValid ? refQ : ~refQ;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pendQ <= 8'h0;
      refQ <= 16'h0100;
      wordCnt <= 16'h0;
      lastCnt <= 16'h0;
      lastRef <= 16'h0;
      freeWrReady <= 1'b0;
    end else begin
      // Stalls one cycle in four to exercise the held word
      freeWrReady <= ($random(seed) & 3) != 0;
      if (offerLoad)
        pendQ <= offerNum;
      else if (readyRefTake && readyRefValid) begin
        pendQ <= pendQ - 8'h1;
        refQ <= refQ + 16'h1;
      end
      if (freeWrValid && freeWrReady) begin
        wordCnt <= wordCnt + 16'h1;
        lastRef <= freeWrRef;
        if (freeWrLast)
          lastCnt <= lastCnt + 16'h1;
      end
    end
  end
endmodule

// *** sim/tx_dma_control_provisioning_tb_top.sv ***
// Self-checking bench for the transmit DMA control block
`timescale 1ns/10ps
module tx_dma_control_provisioning_tb_top;
  reg         core_clk, reset, regWrite, regRead, freedValid, listsPending, offerLoad;
  reg  [11:0] regAddr;
  reg  [3:0]  regByteEn;
  reg  [31:0] regWrData, rd, lo, hi, tmp;
  reg  [7:0]  chainLink, offerNum, c1, c2;
  reg  [14:0] descOffset;
  reg  [15:0] freedRef;
  wire [31:0] regRdData, descAddr;
  wire [15:0] readyRef, chainRef, freeWrRef, hWords, hLasts, hLastRef;
  wire [7:0]  hPend;
  wire        txEnable, readyRefValid, readyRefTake, chainValid, chainAccept, chainReject;
  wire        txActive, freedReady, freeWrValid, freeWrLast, freeWrReady, rIrq, fIrq;
  integer     seed, fails, cmpCount, rdyIrqs, frIrqs, accs, rejs, i, w0, l0;
  txdma_control u_txdma_control (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regByteEn(regByteEn), .regWrData(regWrData),
    .regRdData(regRdData), .txEnable(txEnable), .readyRef(readyRef),
    .readyRefValid(readyRefValid), .readyRefTake(readyRefTake), .chainLink(chainLink),
    .chainValid(chainValid), .chainAccept(chainAccept), .chainReject(chainReject),
    .chainRef(chainRef), .descOffset(descOffset), .descAddr(descAddr),
    .listsPending(listsPending), .txActive(txActive), .freedRef(freedRef),
    .freedValid(freedValid), .freedReady(freedReady), .freeWrRef(freeWrRef),
    .freeWrValid(freeWrValid), .freeWrLast(freeWrLast), .freeWrReady(freeWrReady),
    .readyQueueIrq(rIrq), .freeQueueIrq(fIrq));
  txdma_host_mem u_txdma_host_mem (.core_clk(core_clk), .reset(reset), .offerNum(offerNum),
    .offerLoad(offerLoad), .readyRef(readyRef), .readyRefValid(readyRefValid),
    .readyRefTake(readyRefTake), .freeWrRef(freeWrRef), .freeWrValid(freeWrValid),
    .freeWrLast(freeWrLast), .freeWrReady(freeWrReady), .pendQ(hPend), .wordCnt(hWords),
    .lastCnt(hLasts), .lastRef(hLastRef));
  function integer rdyThr(input integer c);
    rdyThr = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 6 : (c == 3) ? 8 : (c == 4) ? 16 : 32;
  endfunction
  function integer frThr(input integer c);
    frThr = (c == 0) ? 1 : (c == 1) ? 4 : 8;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmpCount = cmpCount + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (fails == 0 && cmpCount > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task guard(input integer n);
    if (n > 100) begin
      fails = fails + 1;
      report_and_stop;
    end
  endtask
  task regWr(input [11:0] a, input [31:0] d, input [3:0] be);
    begin
      @(negedge core_clk);
      regAddr = a;
      regWrData = d;
      regByteEn = be;
      regWrite = 1'b1;
      @(negedge core_clk);
      regWrite = 1'b0;
    end
  endtask
  task regRd(input [11:0] a);
    begin
      @(negedge core_clk);
      regAddr = a;
      regByteEn = 4'hf;
      regRead = 1'b1;
      @(negedge core_clk);
      regRead = 1'b0;
      rd = regRdData;
    end
  endtask
  // Software waits for the bit to drop before the next access
  task poll(input [11:0] a, input integer b);
    integer n;
    begin
      n = 0;
      regRd(a);
      while (rd[b] !== 1'b0) begin
        regRd(a);
        n = n + 1;
        guard(n);
      end
    end
  endtask
  task offer(input [7:0] n);
    integer k;
    begin
      @(negedge core_clk);
      offerNum = n;
      offerLoad = 1'b1;
      @(negedge core_clk);
      offerLoad = 1'b0;
      k = 0;
      while (hPend !== 8'h0) begin
        @(negedge core_clk);
        k = k + 1;
        guard(k);
      end
      repeat (3) @(negedge core_clk);
    end
  endtask
  task pushFreed(input [15:0] d);
    integer n;
    begin
      @(negedge core_clk);
      freedRef = d;
      freedValid = 1'b1;
      n = 0;
      #1;
      while (freedReady !== 1'b1) begin
        @(negedge core_clk);
        #1;
        n = n + 1;
        guard(n);
      end
      @(negedge core_clk);
      freedValid = 1'b0;
    end
  endtask
  task waitWords(input integer t);
    integer n;
    begin
      n = 0;
      while (hWords < t) begin
        @(negedge core_clk);
        n = n + 1;
        guard(n);
      end
      repeat (3) @(negedge core_clk);
    end
  endtask
  always @(posedge core_clk) begin
    if (rIrq === 1'b1) rdyIrqs = rdyIrqs + 1;
    if (fIrq === 1'b1) frIrqs = frIrqs + 1;
    if (chainValid === 1'b1 && chainAccept === 1'b1) accs = accs + 1;
    if (chainValid === 1'b1 && chainReject === 1'b1) rejs = rejs + 1;
  end
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    seed = 32'h65a0;
    {fails, cmpCount, rdyIrqs, frIrqs, accs, rejs} = 0;
    {regWrite, regRead, freedValid, listsPending, offerLoad} = 5'h0;
    {regAddr, regByteEn, regWrData, chainLink, offerNum, descOffset, freedRef} = 0;
    reset = 1'b1;
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    regRd(12'h300); check(rd, 32'h2);
    regRd(12'h320); check(rd, 32'h0);
    regWr(12'h300, 32'h1, 4'h0); regRd(12'h300); check(rd, 32'h2);
    c1 = $random(seed);
    c2 = c1 ^ 8'h5a;
    // Busy written high as well: it must come only from the access state
    regWr(12'h304, {16'h0, 8'ha0, c1}, 4'h1);
    regRd(12'h304); check(rd[15], 1);
    poll(12'h304, 15); check(rd, {16'h0, 8'h20, c1});
    regWr(12'h304, {16'h0, 8'h40, c2}, 4'hf);
    poll(12'h304, 15); check(rd, {16'h0, 8'h40, c2});
    regWr(12'h304, {16'h0, 8'h40, c1}, 4'hf);
    poll(12'h304, 15); check(rd, {16'h0, 8'h60, c1});
    lo = $random(seed) & 32'hfff0;
    hi = $random(seed) & 32'hffff;
    descOffset = $random(seed);
    regWr(12'h308, lo, 4'hf); @(negedge core_clk); check(descAddr, descOffset);
    regWr(12'h30c, hi, 4'hf); @(negedge core_clk);
    check(descAddr, {hi[15:0], lo[15:4], 4'h0} + descOffset);
    chainLink = c2;
    for (i = 0; i < 6; i = i + 1) begin
      regWr(12'h300, (i << 2) | 3, 4'hf);
      tmp = rdyIrqs;
      offer(rdyThr(i));
      check(rdyIrqs - tmp, 1);
    end
    check(rejs, 67);
    chainLink = c1;
    offer(1); check(accs, 1);
    regWr(12'h304, {24'h0, c1}, 4'hf); poll(12'h304, 15);
    offer(1); check(rejs, 68);
    regWr(12'h300, 32'h2, 4'hf);
    offerNum = 4;
    offerLoad = 1'b1;
    @(negedge core_clk);
    offerLoad = 1'b0;
    repeat (10) @(negedge core_clk);
    check(hPend, 4);
    for (i = 0; i < 4; i = i + 1) begin
      listsPending = $random(seed);
      @(negedge core_clk); check(txActive, listsPending);
    end
    regWr(12'h300, 32'h82, 4'hf); poll(12'h300, 7); check(rd, 32'h2);
    repeat (5) @(negedge core_clk);
    w0 = hWords;
    l0 = hLasts;
    for (i = 0; i < 6; i = i + 1) begin
      tmp = $random(seed);
      pushFreed(tmp[15:0]);
    end
    waitWords(w0 + 6); check(hLasts - l0, 1); check(hLastRef, tmp[15:0]);
    for (i = 0; i < 2; i = i + 1) begin
      tmp = $random(seed);
      pushFreed(tmp[15:0]);
    end
    repeat (10) @(negedge core_clk); check(hWords - w0, 6);
    regWr(12'h300, 32'h82, 4'hf); poll(12'h300, 7);
    waitWords(w0 + 8); check(hLasts - l0, 2); check(hLastRef, tmp[15:0]);
    regWr(12'h300, 32'h0, 4'hf);
    for (i = 0; i < 3; i = i + 1) pushFreed($random(seed));
    waitWords(w0 + 11); check(hLasts - l0, 5);
    for (i = 0; i < 3; i = i + 1) begin
      // Cache stays on: the interrupt counts whole blocks of six
      regWr(12'h300, (i << 5) | 2, 4'hf);
      tmp = frIrqs;
      w0 = hWords;
      repeat (6 * frThr(i)) pushFreed($random(seed));
      waitWords(w0 + 6 * frThr(i)); check(frIrqs - tmp, 1);
    end
    report_and_stop;
  end
endmodule
